// file: core/brtc_pkg.sv
package brtc_pkg;
  // Clock register byte addresses at the top of the 32k x 8 space
  localparam logic [14:0] BRTC_CTL_ADDR = 15'h7FF8;
  localparam logic [14:0] BRTC_SEC_ADDR = 15'h7FF9;
  localparam logic [14:0] BRTC_MIN_ADDR = 15'h7FFA;
  localparam logic [14:0] BRTC_HOUR_ADDR = 15'h7FFB;
  localparam logic [14:0] BRTC_DAY_ADDR = 15'h7FFC;
  localparam logic [14:0] BRTC_DATE_ADDR = 15'h7FFD;
  localparam logic [14:0] BRTC_MON_ADDR = 15'h7FFE;
  localparam logic [14:0] BRTC_YEAR_ADDR = 15'h7FFF;

  // Index of each byte within the clock block (low three address bits)
  localparam logic [2:0] BRTC_I_CTL = 3'h0;
  localparam logic [2:0] BRTC_I_SEC = 3'h1;
  localparam logic [2:0] BRTC_I_MIN = 3'h2;
  localparam logic [2:0] BRTC_I_HOUR = 3'h3;
  localparam logic [2:0] BRTC_I_DAY = 3'h4;
  localparam logic [2:0] BRTC_I_DATE = 3'h5;
  localparam logic [2:0] BRTC_I_MON = 3'h6;
  localparam logic [2:0] BRTC_I_YEAR = 3'h7;

  // Control and flag bit positions
  localparam int BRTC_WLOAD_BIT = 7;
  localparam int BRTC_FREEZE_BIT = 6;
  localparam int BRTC_HALT_BIT = 7;
  localparam int BRTC_FCHK_BIT = 6;

  // Value bits held by each time byte
  localparam logic [7:0] BRTC_SEC_MASK = 8'h7F;
  localparam logic [7:0] BRTC_MIN_MASK = 8'h7F;
  localparam logic [7:0] BRTC_HOUR_MASK = 8'h3F;
  localparam logic [7:0] BRTC_DAY_MASK = 8'h07;
  localparam logic [7:0] BRTC_DATE_MASK = 8'h3F;
  localparam logic [7:0] BRTC_MON_MASK = 8'h1F;
  localparam logic [7:0] BRTC_YEAR_MASK = 8'hFF;

  // BCD limits of the counters
  localparam logic [7:0] BRTC_SEC_MAX = 8'h59;
  localparam logic [7:0] BRTC_HOUR_MAX = 8'h23;
  localparam logic [7:0] BRTC_DAY_MAX = 8'h07;
  localparam logic [7:0] BRTC_MON_MAX = 8'h12;
  localparam logic [7:0] BRTC_YEAR_MAX = 8'h99;
  localparam logic [7:0] BRTC_ONE = 8'h01;
  localparam logic [7:0] BRTC_ZERO = 8'h00;

  // Values after reset: 00:00:00, day 1, 01-01-00
  localparam logic [7:0] BRTC_RST_SEC = 8'h00;
  localparam logic [7:0] BRTC_RST_MIN = 8'h00;
  localparam logic [7:0] BRTC_RST_HOUR = 8'h00;
  localparam logic [7:0] BRTC_RST_DAY = 8'h01;
  localparam logic [7:0] BRTC_RST_DATE = 8'h01;
  localparam logic [7:0] BRTC_RST_MON = 8'h01;
  localparam logic [7:0] BRTC_RST_YEAR = 8'h00;

  // Timing: half period of the 512 Hz check signal, 1024 halves a second
  localparam int BRTC_CLK_PERIOD_NS = 100;
  localparam int BRTC_CHECK_HZ = 512;
  localparam int BRTC_CHECK_HALF_NS = 1000000000 / (2 * BRTC_CHECK_HZ);
  localparam int BRTC_CHECK_HALF_CYCLES =
    BRTC_CHECK_HALF_NS / BRTC_CLK_PERIOD_NS;
  localparam logic [9:0] BRTC_LAST_HALF = 10'h3FF;

  typedef enum logic [1:0] {BRTC_IDLE, BRTC_READ, BRTC_WRITE} brtc_mode_t;

  // Time bytes indexed by the low address bits, 1 = seconds .. 7 = year
  typedef logic [7:1][7:0] brtc_time_t;
endpackage

// file: core/brtc_calendar.sv
`timescale 1ns/1ps
module brtc_calendar (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic tick, // One-second pulse
  input wire logic load, // Load pulse from the visible bytes
  input wire brtc_pkg::brtc_time_t load_time, // Values to load
  output brtc_pkg::brtc_time_t run_time // Running counter values
);
  import brtc_pkg::*;

  typedef struct packed {
    brtc_time_t t;
  } brtc_cal_state_t;

  brtc_cal_state_t s;
  brtc_cal_state_t next_s;

  // One BCD step up
  function automatic logic [7:0] brtc_inc(input logic [7:0] v);
    if (v[3:0] >= 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Leap year on a BCD year, valid for 2000 to 2099
  function automatic logic brtc_leap(input logic [7:0] y);
    if (y[4])
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  // Last date of a month in BCD
  function automatic logic [7:0] brtc_last(input logic [7:0] m,
                                          input logic [7:0] y);
    unique case (m)
      8'h02: return brtc_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  logic c_sec;
  logic c_min;
  logic c_hour;
  logic c_date;
  logic c_mon;

  // Carry chain through the calendar fields
  always_comb
  begin
    next_s = s;
    c_sec = s.t[BRTC_I_SEC] >= BRTC_SEC_MAX;
    c_min = c_sec && (s.t[BRTC_I_MIN] >= BRTC_SEC_MAX);
    c_hour = c_min && (s.t[BRTC_I_HOUR] >= BRTC_HOUR_MAX);
    c_date = c_hour && (s.t[BRTC_I_DATE] >=
      brtc_last(s.t[BRTC_I_MON], s.t[BRTC_I_YEAR]));
    c_mon = c_date && (s.t[BRTC_I_MON] >= BRTC_MON_MAX);
    if (load)
    begin
      next_s.t = load_time; // [R05]
    end
    else if (tick)
    begin
      // Wrap each field in its range and carry onward [R24] [R06]
      next_s.t[BRTC_I_SEC] = c_sec ? BRTC_ZERO : brtc_inc(s.t[BRTC_I_SEC]);
      if (c_sec)
        next_s.t[BRTC_I_MIN] = c_min ? BRTC_ZERO : brtc_inc(s.t[BRTC_I_MIN]);
      if (c_min)
        next_s.t[BRTC_I_HOUR] = c_hour ? BRTC_ZERO :
          brtc_inc(s.t[BRTC_I_HOUR]);
      if (c_hour)
      begin
        next_s.t[BRTC_I_DAY] = (s.t[BRTC_I_DAY] >= BRTC_DAY_MAX) ?
          BRTC_ONE : brtc_inc(s.t[BRTC_I_DAY]);
        // Month length and leap year correction [R23]
        next_s.t[BRTC_I_DATE] = c_date ? BRTC_ONE :
          brtc_inc(s.t[BRTC_I_DATE]);
      end
      if (c_date)
        next_s.t[BRTC_I_MON] = c_mon ? BRTC_ONE : brtc_inc(s.t[BRTC_I_MON]);
      if (c_mon)
        next_s.t[BRTC_I_YEAR] = (s.t[BRTC_I_YEAR] >= BRTC_YEAR_MAX) ?
          BRTC_ZERO : brtc_inc(s.t[BRTC_I_YEAR]);
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '{t: {BRTC_RST_YEAR, BRTC_RST_MON, BRTC_RST_DATE, BRTC_RST_DAY,
                 BRTC_RST_HOUR, BRTC_RST_MIN, BRTC_RST_SEC}};
    else
      s <= next_s;
  end

  assign run_time = s.t;

  AST_FEB_END: assert property (@(posedge clk) disable iff (!reset_n) // [R23]
    (tick && !load && c_hour && s.t[BRTC_I_MON] == 8'h02 &&
     s.t[BRTC_I_DATE] == 8'h28 && !brtc_leap(s.t[BRTC_I_YEAR]))
    |=> (s.t[BRTC_I_DATE] == 8'h01 && s.t[BRTC_I_MON] == 8'h03))
    else $error("February did not end on the 28th");
  AST_MIDNIGHT: assert property (@(posedge clk) disable iff (!reset_n) // [R24]
    (tick && !load && c_hour) |=> (s.t[BRTC_I_HOUR] == 8'h00 &&
     s.t[BRTC_I_MIN] == 8'h00 && s.t[BRTC_I_SEC] == 8'h00))
    else $error("Time did not wrap at midnight");
endmodule

// file: core/brtc_top.sv
`timescale 1ns/1ps
// Operation
// R01: A 1 in the freeze bit stops visible clock byte updates while it stays.
// R02: Frozen bytes keep their time while the hidden counters keep counting.
// R03: Clearing freeze refreshes all visible bytes together within a second.
// R04: Control bit 7 is write-load; setting it halts updates for loading.
// R05: Clearing write-load copies the loaded bytes into the counters.
// R06: All time bytes are BCD, hours in 24-hour form, loaded likewise.
// R07: Seconds bit 7 stops the oscillator and timekeeping at any time.
// R08: Day bit 6 makes seconds bit 0 toggle at 512 Hz while running.
// R09: A steady read of seconds shows that bit 0 toggling live.
// R10: The host writes zero to all unused clock and control bits.
// R11: Control holds write-load and freeze, seconds stop, day the check bit.
// R12: Write strobe high with chip select low is read mode.
// R13: Data pins drive only when selected, reading, and output drive low.
// R14: Read data follows the address with a short hold, no strobe needed.
// R15: Write mode while strobe and select are both low.
// R16: The host holds address through a write and ends it before the next.
// R17: Write data is taken at the end of the write.
// R18: Output drive low before the strobe falls drives data until it falls.
// R19: Below the trip level select is inhibited and accesses blocked.
// R20: Below the trip level the supply fail output stays low.
// R21: Timekeeping and contents survive when the supply drops to battery.
// R22: Clock bytes sit in the top eight locations; the rest is plain RAM.
// R23: The date corrects for month lengths and leap years.
// R24: Every counter wraps within its range and carries to the next.
module brtc_top #(
  parameter int HALF_CYCLES = brtc_pkg::BRTC_CHECK_HALF_CYCLES // Check half
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic chip_sel_n, // Chip select, active low
  input wire logic out_drive_n, // Output drive enable, active low
  input wire logic write_strobe_n, // Write strobe, active low
  input wire logic [14:0] addr, // Byte address
  input wire logic [7:0] data_in, // Data pins, input side
  output logic [7:0] data_out, // Data pins, output side
  output logic data_oe, // Data pins driven when high
  input wire logic supply_above_trip, // Supply above the trip level
  output logic supply_fail_out_n // Supply fail output, active low
);
  import brtc_pkg::*;

  typedef struct packed {
    brtc_mode_t mode;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] dout;
    logic doe;
    logic fail_out_n;
    logic ctl_w;
    logic ctl_r;
    logic halt;
    logic fchk;
    brtc_time_t vis;
    logic [13:0] div_cnt;
    logic [9:0] half_cnt;
    logic check_phase;
    logic tick;
    logic load;
  } brtc_top_state_t;

  brtc_top_state_t s;
  brtc_top_state_t next_s;
  brtc_time_t run_time;
  logic [7:0] mem [0:32767];
  logic sel;
  logic wr_now;
  logic rd_now;
  logic commit;
  logic [7:0] rdata;

  // Value bits kept for each time byte
  function automatic logic [7:0] brtc_mask(input logic [2:0] i);
    unique case (i)
      BRTC_I_SEC: return BRTC_SEC_MASK;
      BRTC_I_MIN: return BRTC_MIN_MASK;
      BRTC_I_HOUR: return BRTC_HOUR_MASK;
      BRTC_I_DAY: return BRTC_DAY_MASK;
      BRTC_I_DATE: return BRTC_DATE_MASK;
      BRTC_I_MON: return BRTC_MON_MASK;
      BRTC_I_YEAR: return BRTC_YEAR_MASK;
      default: return BRTC_ZERO;
    endcase
  endfunction

  // Hidden running counters
  brtc_calendar u_calendar (
    .clk(clk),
    .reset_n(reset_n),
    .tick(s.tick),
    .load(s.load),
    .load_time(s.vis),
    .run_time(run_time)
  );

  // Bus decode, register file, oscillator divider and output staging
  always_comb
  begin
    next_s = s;
    sel = !chip_sel_n && supply_above_trip; // [R19]
    wr_now = sel && !write_strobe_n; // [R15]
    rd_now = sel && write_strobe_n; // [R12]
    commit = (s.mode == BRTC_WRITE) && !wr_now && supply_above_trip;
    rdata = BRTC_ZERO;
    next_s.tick = 1'b0;
    next_s.load = 1'b0;
    next_s.mode = wr_now ? BRTC_WRITE : (rd_now ? BRTC_READ : BRTC_IDLE);
    // Keep the last sample before the write ends [R17] [R16]
    if (wr_now)
    begin
      next_s.wr_addr = addr;
      next_s.wr_data = data_in;
    end
    // Oscillator runs from the core clock, even on battery [R07] [R21]
    if (!s.halt)
    begin
      if (s.div_cnt == 14'(HALF_CYCLES - 1))
      begin
        next_s.div_cnt = 14'h0000;
        next_s.check_phase = !s.check_phase; // [R08]
        next_s.half_cnt = s.half_cnt + 10'h001;
        next_s.tick = (s.half_cnt == BRTC_LAST_HALF);
      end
      else
        next_s.div_cnt = s.div_cnt + 14'h0001;
    end
    // Visible bytes follow the counters unless frozen or loading
    if (!s.ctl_w && !s.ctl_r && !s.load) // [R01] [R02] [R03] [R04]
      next_s.vis = run_time;
    // Host write into the clock bytes
    if (commit && s.wr_addr >= BRTC_CTL_ADDR) // [R22]
    begin
      unique case (s.wr_addr[2:0])
        BRTC_I_CTL:
        begin
          next_s.ctl_w = s.wr_data[BRTC_WLOAD_BIT]; // [R11]
          next_s.ctl_r = s.wr_data[BRTC_FREEZE_BIT]; // [R11]
          if (s.ctl_w && !s.wr_data[BRTC_WLOAD_BIT])
          begin
            next_s.load = 1'b1; // [R05]
            next_s.div_cnt = 14'h0000;
            next_s.half_cnt = 10'h000;
          end
        end
        BRTC_I_SEC:
        begin
          next_s.halt = s.wr_data[BRTC_HALT_BIT]; // [R07] [R11]
          next_s.vis[BRTC_I_SEC] = s.wr_data & BRTC_SEC_MASK;
        end
        BRTC_I_DAY:
        begin
          next_s.fchk = s.wr_data[BRTC_FCHK_BIT]; // [R08] [R11]
          next_s.vis[BRTC_I_DAY] = s.wr_data & BRTC_DAY_MASK;
        end
        default:
          next_s.vis[s.wr_addr[2:0]] = s.wr_data & brtc_mask(s.wr_addr[2:0]);
      endcase
    end
    // Read data follows the address every cycle [R14]
    if (addr >= BRTC_CTL_ADDR)
    begin
      unique case (addr[2:0])
        BRTC_I_CTL: rdata = {s.ctl_w, s.ctl_r, 6'h00};
        BRTC_I_SEC:
        begin
          rdata = {s.halt, s.vis[BRTC_I_SEC][6:0]};
          if (s.fchk && !s.halt)
            rdata[0] = s.check_phase; // [R09]
        end
        BRTC_I_DAY: rdata = {1'b0, s.fchk, 3'h0, s.vis[BRTC_I_DAY][2:0]};
        default: rdata = s.vis[addr[2:0]];
      endcase
    end
    else
      rdata = mem[addr];
    next_s.dout = rdata;
    next_s.doe = rd_now && !out_drive_n; // [R13] [R18]
    next_s.fail_out_n = supply_above_trip; // [R20]
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.mode <= BRTC_IDLE;
      s.fail_out_n <= 1'b1;
      s.vis <= {BRTC_RST_YEAR, BRTC_RST_MON, BRTC_RST_DATE, BRTC_RST_DAY,
                BRTC_RST_HOUR, BRTC_RST_MIN, BRTC_RST_SEC};
    end
    else
      s <= next_s;
  end

  // Plain RAM below the clock bytes, contents kept through reset
  always_ff @(posedge clk)
  begin
    if (commit && s.wr_addr < BRTC_CTL_ADDR)
      mem[s.wr_addr] <= s.wr_data; // [R22] [R17]
  end

  assign data_out = s.dout;
  assign data_oe = s.doe;
  assign supply_fail_out_n = s.fail_out_n;

  // Freeze and write-load both hold the visible bytes
  AST_FREEZE_HOLD: assert property ( // [R01] [R02]
    @(posedge clk) disable iff (!reset_n)
    (s.ctl_r && !commit) |=> $stable(s.vis))
    else $error("Visible bytes moved while frozen");
  AST_WLOAD_HOLD: assert property ( // [R04]
    @(posedge clk) disable iff (!reset_n)
    (s.ctl_w && !commit) |=> $stable(s.vis))
    else $error("Visible bytes moved while loading");

  // Visible bytes track the counters, one cycle behind
  AST_REFRESH: assert property ( // [R03]
    @(posedge clk) disable iff (!reset_n)
    (!s.ctl_w && !s.ctl_r && !s.load && !commit)
    |=> (s.vis == $past(run_time)))
    else $error("Visible bytes did not follow the counters");

  // Ending write-load hands the bytes to the counters
  AST_LOAD: assert property ( // [R05]
    @(posedge clk) disable iff (!reset_n)
    (commit && s.wr_addr == BRTC_CTL_ADDR && s.ctl_w &&
     !s.wr_data[BRTC_WLOAD_BIT]) |=> s.load ##1 (run_time == $past(s.vis)))
    else $error("Loaded values did not reach the counters");

  // Control, stop and check bits are stored and read back in place
  AST_CTL_BITS: assert property ( // [R11]
    @(posedge clk) disable iff (!reset_n)
    (commit && s.wr_addr == BRTC_CTL_ADDR)
    |=> (s.ctl_w == $past(s.wr_data[BRTC_WLOAD_BIT]) &&
         s.ctl_r == $past(s.wr_data[BRTC_FREEZE_BIT])))
    else $error("Control bits not stored");
  AST_READ_CTL: assert property ( // [R11] [R14]
    @(posedge clk) disable iff (!reset_n)
    (rd_now && addr == BRTC_CTL_ADDR)
    |=> (data_out == {$past(s.ctl_w), $past(s.ctl_r), 6'h00}))
    else $error("Control byte read back wrong");
  AST_HALT_READ: assert property ( // [R07] [R11]
    @(posedge clk) disable iff (!reset_n)
    (rd_now && addr == BRTC_SEC_ADDR)
    |=> (data_out[BRTC_HALT_BIT] == $past(s.halt)))
    else $error("Stop bit not read back");
  AST_DAY_READ: assert property ( // [R08] [R11]
    @(posedge clk) disable iff (!reset_n)
    (rd_now && addr == BRTC_DAY_ADDR)
    |=> (data_out[BRTC_FCHK_BIT] == $past(s.fchk)))
    else $error("Check bit not read back");

  // Read data and pin drive
  AST_READ_DRIVE: assert property ( // [R12] [R14]
    @(posedge clk) disable iff (!reset_n)
    (rd_now && !out_drive_n) |=> (data_oe && data_out == $past(rdata)))
    else $error("Read did not drive the data pins");
  AST_HIGH_Z: assert property ( // [R13] [R18]
    @(posedge clk) disable iff (!reset_n)
    (chip_sel_n || out_drive_n || !write_strobe_n) |=> !data_oe)
    else $error("Data pins driven outside a read");

  // Supply fail blocks access and shows on the fail output
  AST_SUPPLY_FAIL: assert property ( // [R19] [R20]
    @(posedge clk) disable iff (!reset_n)
    !supply_above_trip |=> (!supply_fail_out_n && !data_oe))
    else $error("Access not blocked under supply fail");
  AST_BLOCK_WRITE: assert property ( // [R19]
    @(posedge clk) disable iff (!reset_n)
    !supply_above_trip |=> (s.mode == BRTC_IDLE && !s.load))
    else $error("Write taken under supply fail");

  // Check signal, stop bit and RAM writes; a load may restart the divider
  AST_CHECK_BIT: assert property ( // [R09]
    @(posedge clk) disable iff (!reset_n)
    (rd_now && addr == BRTC_SEC_ADDR && s.fchk && !s.halt)
    |=> (data_out[0] == $past(s.check_phase)))
    else $error("Seconds bit 0 does not show the check signal");
  AST_CHECK_RATE: assert property ( // [R08]
    @(posedge clk) disable iff (!reset_n)
    (!s.halt && s.div_cnt == 14'(HALF_CYCLES - 1))
    |=> (s.check_phase != $past(s.check_phase)))
    else $error("Check signal missed a half period");
  AST_HALT_STOP: assert property ( // [R07]
    @(posedge clk) disable iff (!reset_n)
    (s.halt && $past(s.halt) && !s.load)
    |-> ($stable(s.div_cnt) && !s.tick))
    else $error("Timekeeping ran while stopped");
  AST_WRITE_RAM: assert property ( // [R15] [R17]
    @(posedge clk) disable iff (!reset_n)
    (commit && s.wr_addr < BRTC_CTL_ADDR)
    |=> (mem[$past(s.wr_addr)] == $past(s.wr_data)))
    else $error("RAM write lost");

  // Main scenarios
  COV_FREEZE: cover property (@(posedge clk) disable iff (!reset_n)
    s.ctl_r ##1 !s.ctl_r);
  COV_LOAD: cover property (@(posedge clk) disable iff (!reset_n) s.load);
  COV_CHECK_READ: cover property (@(posedge clk) disable iff (!reset_n)
    (rd_now && addr == BRTC_SEC_ADDR && s.fchk && s.check_phase));
  COV_FAIL: cover property (@(posedge clk) disable iff (!reset_n)
    (s.mode == BRTC_WRITE) ##1 !supply_above_trip);
  COV_TICK: cover property (@(posedge clk) disable iff (!reset_n)
    s.tick && !s.load);
endmodule

// file: dv/brtc_host.sv
`timescale 1ns/1ps
module brtc_host (
  input wire logic clk, // System clock
  output logic chip_sel_n, // Chip select, active low
  output logic out_drive_n, // Output drive, active low
  output logic write_strobe_n, // Write strobe, active low
  output logic [14:0] addr, // Byte address
  output logic [7:0] data_in, // Write data toward the device
  input wire logic [7:0] data_out, // Read data from the device
  input wire logic data_oe // Device drives the data pins
);
  int slow = 0; // Extra strobe cycles when the host stalls

  // Bus idle from time zero
  initial
  begin
    chip_sel_n = 1'b1;
    out_drive_n = 1'b1;
    write_strobe_n = 1'b1;
    addr = 15'h0000;
    data_in = 8'h00;
  end

  // Write: select and strobe low together, address and data held to the end
  task write_byte(input logic [14:0] a, input logic [7:0] d);
    @(negedge clk);
    chip_sel_n = 1'b0;
    write_strobe_n = 1'b0;
    out_drive_n = 1'b1;
    addr = a;
    data_in = d;
    repeat (slow + 1) @(negedge clk);
    chip_sel_n = 1'b1;
    write_strobe_n = 1'b1;
    data_in = ~d; // Released lines no longer show the last value
  endtask

  // Read: one cycle selected, answer taken one edge later, then released
  task read_byte(input logic [14:0] a, input logic oe_n, output logic [7:0] d,
                 output logic v);
    @(negedge clk);
    chip_sel_n = 1'b0;
    write_strobe_n = 1'b1;
    out_drive_n = oe_n;
    addr = a;
    @(negedge clk);
    d = data_out;
    v = data_oe;
    chip_sel_n = 1'b1;
    out_drive_n = 1'b1;
  endtask

  // Steady read held for n + 1 cycles, counting changes of data bit zero over the last n
  task read_hold(input logic [14:0] a, input int n, output int flips);
    logic last;
    flips = 0;
    @(negedge clk);
    chip_sel_n = 1'b0;
    write_strobe_n = 1'b1;
    out_drive_n = 1'b0;
    addr = a;
    @(negedge clk);
    last = data_out[0];
    repeat (n)
    begin
      @(negedge clk);
      if (data_out[0] !== last)
        flips++;
      last = data_out[0];
    end
    chip_sel_n = 1'b1;
    out_drive_n = 1'b1;
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import brtc_pkg::*;
  localparam int HALF = 4;
  localparam int SEC = HALF * 1024;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic supply_above_trip = 1'b1;
  logic chip_sel_n;
  logic out_drive_n;
  logic write_strobe_n;
  logic [14:0] addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe;
  logic supply_fail_out_n;
  logic [7:0] rd;
  logic v;
  int flips;
  int n_mismatch = 0;
  int checks = 0;
  // Loaded times and the time one second later: year down to seconds
  brtc_time_t ld [3] = '{
    {8'h03, 8'h02, 8'h28, 8'h07, 8'h23, 8'h59, 8'h59},
    {8'h04, 8'h02, 8'h28, 8'h07, 8'h23, 8'h59, 8'h59},
    {8'h99, 8'h12, 8'h31, 8'h03, 8'h23, 8'h59, 8'h59}};
  brtc_time_t ex [3] = '{
    {8'h03, 8'h03, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00},
    {8'h04, 8'h02, 8'h29, 8'h01, 8'h00, 8'h00, 8'h00},
    {8'h00, 8'h01, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00}};

  // Clock of 100 ns period
  always #50 clk = ~clk;

  brtc_top #(.HALF_CYCLES(HALF)) i_brtc_top (.clk(clk), .reset_n(reset_n),
    .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n),
    .write_strobe_n(write_strobe_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe),
    .supply_above_trip(supply_above_trip),
    .supply_fail_out_n(supply_fail_out_n));

  brtc_host i_brtc_host (.clk(clk), .chip_sel_n(chip_sel_n),
    .out_drive_n(out_drive_n), .write_strobe_n(write_strobe_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  task chk_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t byte %h expected %h", $time, g, e);
    end
  endtask

  task chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Load a full time through the write-load bit
  task load(input brtc_time_t t);
    i_brtc_host.write_byte(BRTC_CTL_ADDR, 8'h80);
    for (int i = 1; i < 8; i++)
      i_brtc_host.write_byte(BRTC_CTL_ADDR + 15'(i), t[i]);
    i_brtc_host.write_byte(BRTC_CTL_ADDR, 8'h00);
  endtask

  // Plain RAM below the clock bytes, with a stalling host
  task t_ram;
    i_brtc_host.slow = 2;
    i_brtc_host.write_byte(15'h0000, 8'hA5);
    i_brtc_host.write_byte(15'h7FF7, 8'h5A);
    i_brtc_host.slow = 0;
    i_brtc_host.read_byte(15'h0000, 1'b0, rd, v);
    chk_byte(rd, 8'hA5);
    chk_bit(v, 1'b1);
    i_brtc_host.read_byte(15'h7FF7, 1'b0, rd, v);
    chk_byte(rd, 8'h5A);
    i_brtc_host.read_byte(15'h7FF7, 1'b1, rd, v);
    chk_bit(v, 1'b0);
    @(negedge clk);
    chk_bit(data_oe, 1'b0);
  endtask

  // Rollovers, freeze and release of the visible bytes
  task t_calendar;
    for (int k = 0; k < 3; k++)
    begin
      load(ld[k]);
      repeat (SEC + 200) @(negedge clk);
      i_brtc_host.write_byte(BRTC_CTL_ADDR, 8'h40);
      for (int i = 1; i < 8; i++)
      begin
        i_brtc_host.read_byte(BRTC_CTL_ADDR + 15'(i), 1'b0, rd, v);
        chk_byte(rd, ex[k][i]);
      end
      if (k == 0)
      begin
        repeat (SEC + 900) @(negedge clk);
        i_brtc_host.read_byte(BRTC_SEC_ADDR, 1'b0, rd, v);
        chk_byte(rd, 8'h00);
        i_brtc_host.write_byte(BRTC_CTL_ADDR, 8'h00);
        // Visible bytes refresh one cycle after the release lands
        @(negedge clk);
        i_brtc_host.read_byte(BRTC_SEC_ADDR, 1'b0, rd, v);
        chk_byte(rd, 8'h01);
      end
      else
        i_brtc_host.write_byte(BRTC_CTL_ADDR, 8'h00);
    end
  endtask

  // Oscillator stop, then the frequency check on a steady read
  task t_stop;
    load({8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h90});
    repeat (SEC + 900) @(negedge clk);
    i_brtc_host.read_byte(BRTC_SEC_ADDR, 1'b0, rd, v);
    chk_byte(rd, 8'h90);
    load({8'h00, 8'h01, 8'h01, 8'h41, 8'h00, 8'h00, 8'h00});
    i_brtc_host.read_byte(BRTC_DAY_ADDR, 1'b0, rd, v);
    chk_byte(rd, 8'h41);
    i_brtc_host.read_hold(BRTC_SEC_ADDR, 8 * HALF, flips);
    chk_bit(flips >= 7 && flips <= 8, 1'b1);
  endtask

  // Supply below the trip level blocks access and keeps contents
  task t_supply;
    @(negedge clk);
    supply_above_trip = 1'b0;
    @(negedge clk);
    chk_bit(supply_fail_out_n, 1'b0);
    i_brtc_host.write_byte(15'h0000, 8'h3C);
    i_brtc_host.read_byte(15'h0000, 1'b0, rd, v);
    chk_bit(v, 1'b0);
    chk_bit(supply_fail_out_n, 1'b0);
    supply_above_trip = 1'b1;
    @(negedge clk);
    chk_bit(supply_fail_out_n, 1'b1);
    i_brtc_host.read_byte(15'h0000, 1'b0, rd, v);
    chk_byte(rd, 8'hA5);
  endtask

  // Main sequence after reset
  initial
  begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_ram;
    t_calendar;
    t_stop;
    t_supply;
    stop_test;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test;
  end
endmodule
